/* load_ctrl.sv */
// Behaviour
// - Master role: low load request starts the EEPROM register read.
// - After load, request may stay low without restart or disturbance.
// - Master role: done output stays high while loading or after failure.
// - Master role: done output goes low only after successful load.
// - Slave role: low request holds serial state machine and registers in reset.
// - Interrupt pin pulls low on an enabled event, released otherwise.
// - Software selects which events drive the interrupt.
// - Interrupt pin only pulls low, never drives high.
// - Outside test mode, test pins are inputs with no effect.
`include "load_ctrl_regs.svh"
`default_nettype none
module load_ctrl
(
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Straps and pins
   input  wire logic [1:0]                bus_role_strap,
   input  wire logic                      load_req_n,
   output var  logic                      all_done_n,
   // EEPROM read engine handshake
   output var  logic                      eeprom_start,
   input  wire logic                      eeprom_busy,
   input  wire logic                      eeprom_ok,
   input  wire logic                      eeprom_fail,
   // Serial interface and register bank reset
   output var  logic                      regs_reset,
   // Interrupt sources and enables from the register bank
   input  wire logic [`EVENT_COUNT-1:0]   event_in,
   input  wire logic [`EVENT_COUNT-1:0]   event_enable,
   output var  logic                      int_n_out,
   output var  logic                      int_n_oe_n,
   // Factory test pins, inputs only, and the test mode output
   input  wire logic                      factory_test_in_a,
   input  wire logic                      factory_test_in_b,
   input  wire logic                      factory_test_in_c,
   input  wire logic                      factory_test_in_d,
   input  wire logic                      factory_test_in_e,
   input  wire logic                      factory_test_in_f,
   output var  logic                      test_mode_active
);
   load_ctrl_pkg::bus_role_e   role_q;
   load_ctrl_pkg::bus_role_e   role_d;
   logic                       role_valid_q;
   load_ctrl_pkg::load_state_e state_q;
   load_ctrl_pkg::load_state_e state_d;
   logic [5:0]                 test_pins;

   wire is_master;
   wire is_slave;
   wire is_test;
   wire test_pins_all;
   wire start_d;
   wire done_n_d;
   wire regs_reset_d;
   wire test_mode_d;

   // Strap is caught once after reset release, not under the async reset
   assign role_d = (bus_role_strap == `STRAP_FLOAT) ? load_ctrl_pkg::ROLE_MASTER :
                   (bus_role_strap == `STRAP_VDD)   ? load_ctrl_pkg::ROLE_SLAVE  :
                                                      load_ctrl_pkg::ROLE_TEST;
   assign is_master = role_valid_q && (role_q == load_ctrl_pkg::ROLE_MASTER);
   assign is_slave  = role_valid_q && (role_q == load_ctrl_pkg::ROLE_SLAVE);
   assign is_test   = role_valid_q && (role_q == load_ctrl_pkg::ROLE_TEST);

   // Test pins gathered into one word so a single reduction covers them
   assign test_pins[0] = factory_test_in_a;
   assign test_pins[1] = factory_test_in_b;
   assign test_pins[2] = factory_test_in_c;
   assign test_pins[3] = factory_test_in_d;
   assign test_pins[4] = factory_test_in_e;
   assign test_pins[5] = factory_test_in_f;
   // Test pins only matter when the reserved strap selects test mode
   assign test_pins_all = &test_pins;

   // Next values of the registered pins, kept out of the flop blocks
   assign start_d      = (state_d == load_ctrl_pkg::LD_START);
   // Slave role mirrors the request; master role shows the load result, test role holds done high
   assign done_n_d     = is_slave ? load_req_n :
                         ~(is_master && (state_d == load_ctrl_pkg::LD_OK));
   // Registers held while role is unknown or slave request is low
   assign regs_reset_d = !role_valid_q || (is_slave && !load_req_n);
   assign test_mode_d  = is_test && test_pins_all;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         role_q       <= load_ctrl_pkg::ROLE_TEST;
         role_valid_q <= 1'b0;
      end
      else if (!role_valid_q)
      begin
         role_q       <= role_d;
         role_valid_q <= 1'b1;
      end
   end

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         load_ctrl_pkg::LD_IDLE:
         begin
            // Only the master role loads; slave and test roles stay idle
            if (is_master && !load_req_n)
            begin
               state_d = load_ctrl_pkg::LD_START;
            end
         end
         load_ctrl_pkg::LD_START:
         begin
            state_d = load_ctrl_pkg::LD_BUSY;
         end
         load_ctrl_pkg::LD_BUSY:
         begin
            if (eeprom_ok)
            begin
               state_d = load_ctrl_pkg::LD_OK;
            end
            else if (eeprom_fail)
            begin
               state_d = load_ctrl_pkg::LD_FAIL;
            end
            // Engine dropped busy with no verdict: the load is incomplete.
            // Limitation: the engine must show busy one cycle after start.
            else if (!eeprom_busy)
            begin
               state_d = load_ctrl_pkg::LD_FAIL;
            end
         end
         // Terminal: a held-low request never restarts; only reset re-arms
         load_ctrl_pkg::LD_OK:
         begin
            state_d = load_ctrl_pkg::LD_OK;
         end
         load_ctrl_pkg::LD_FAIL:
         begin
            state_d = load_ctrl_pkg::LD_FAIL;
         end
         default:
         begin
            state_d = load_ctrl_pkg::LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= load_ctrl_pkg::LD_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // One-cycle pulse, so a busy engine never sees a second start
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         eeprom_start <= 1'h0;
      end
      else
      begin
         eeprom_start <= start_d;
      end
   end

   // Reset shows an incomplete load on the done pin
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         all_done_n <= `DONE_N_RST;
      end
      else
      begin
         all_done_n <= done_n_d;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         regs_reset <= 1'h1;
      end
      else
      begin
         regs_reset <= regs_reset_d;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         test_mode_active <= 1'h0;
      end
      else
      begin
         test_mode_active <= test_mode_d;
      end
   end

   irq_pulldown u_irq
   (
      .clk          (clk),
      .rst          (rst),
      .event_in     (event_in),
      .event_enable (event_enable),
      .int_n_out    (int_n_out),
      .int_n_oe_n   (int_n_oe_n)
   );
endmodule : load_ctrl
`default_nettype wire

/* load_ctrl_regs.svh */
`ifndef LOAD_CTRL_REGS_SVH
`define LOAD_CTRL_REGS_SVH
// Strap level codes
`define STRAP_GND_1K   2'h0
`define STRAP_GND_10K  2'h1
`define STRAP_FLOAT    2'h2
`define STRAP_VDD      2'h3
// Reset values
`define DONE_N_RST     1'b1
`define INT_N_OE_RST   1'b1
// Number of interrupt event sources
`define EVENT_COUNT    8
`endif

/* load_ctrl_pkg.sv */
`default_nettype none
package load_ctrl_pkg;
   typedef enum logic [1:0]
   {
      ROLE_TEST,
      ROLE_MASTER,
      ROLE_SLAVE
   } bus_role_e;
   typedef enum logic [2:0]
   {
      LD_IDLE,
      LD_START,
      LD_BUSY,
      LD_OK,
      LD_FAIL
   } load_state_e;
endpackage : load_ctrl_pkg
`default_nettype wire

/* irq_pulldown.sv */
`include "load_ctrl_regs.svh"
`default_nettype none
module irq_pulldown
(
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Events and enables
   input  wire logic [`EVENT_COUNT-1:0]   event_in,
   input  wire logic [`EVENT_COUNT-1:0]   event_enable,
   // Open-drain pin, enable low means pulling low
   output var  logic                      int_n_out,
   output var  logic                      int_n_oe_n
);
   logic [`EVENT_COUNT-1:0] hit;
   wire                     any_hit;

   genvar g;
   generate
      for (g = 0; g < `EVENT_COUNT; g = g + 1)
      begin : gen_gate
         assign hit[g] = event_in[g] & event_enable[g];
      end
   endgenerate

   assign any_hit = |hit;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         int_n_oe_n <= `INT_N_OE_RST;
         int_n_out  <= 1'b0;
      end
      else
      begin
         // Data is always low; only the enable moves, so the pin never drives high
         int_n_out  <= 1'b0;
         int_n_oe_n <= ~any_hit;
      end
   end
endmodule : irq_pulldown
`default_nettype wire

/* eeprom_model.sv */
`default_nettype none
module eeprom_model
(
   // Read engine handshake
   input  wire logic clk,
   input  wire logic eeprom_start,
   input  wire logic fail_mode,
   output var  logic eeprom_busy,
   output var  logic eeprom_ok,
   output var  logic eeprom_fail
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {eeprom_busy, eeprom_ok, eeprom_fail} = 3'h0;
      forever
      begin
         @(posedge clk iff eeprom_start);
         #1 eeprom_busy = 1'h1;
         // A failing read answers slowly, a good one promptly
         repeat (fail_mode ? 9 : 3) @(posedge clk);
         #1 {eeprom_busy, eeprom_ok, eeprom_fail} = {1'h0, !fail_mode, fail_mode};
         @(posedge clk);
         #1 {eeprom_ok, eeprom_fail} = 2'h0;
      end
   end
endmodule : eeprom_model
`default_nettype wire

/* load_ctrl_sva.sv */
`default_nettype none
module load_ctrl_sva
(
   // Pins
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [1:0] bus_role_strap,
   input wire logic       load_req_n,
   input wire logic       all_done_n,
   input wire logic       eeprom_start,
   input wire logic       eeprom_ok,
   input wire logic       eeprom_fail,
   input wire logic       regs_reset,
   input wire logic [7:0] event_in,
   input wire logic [7:0] event_enable,
   input wire logic       int_n_out,
   input wire logic       int_n_oe_n,
   input wire logic       test_mode_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire m = bus_role_strap == 2'h2;
   wire s = bus_role_strap == 2'h3;
   wire hit = |(event_in & event_enable);
   irq_pull_a: assert property (hit |=> !int_n_oe_n) else $error("irq not pulled");
   irq_free_a: assert property (!hit |=> int_n_oe_n) else $error("irq not freed");
   only_low_a: assert property (!int_n_out) else $error("irq driven high");
   start_req_a: assert property (eeprom_start |-> !$past(load_req_n)) else $error("bad start");
   ok_done_a: assert property (m && eeprom_ok |=> !all_done_n) else $error("no done");
   fail_high_a: assert property (m && eeprom_fail |=> all_done_n) else $error("done on fail");
   done_cause_a: assert property (m && $fell(all_done_n) |-> $past(eeprom_ok)) else $error("early done");
   done_keep_a: assert property (m && !all_done_n |=> !all_done_n) else $error("done lost");
   slave_done_a: assert property (s ##1 s |=> all_done_n == $past(load_req_n)) else $error("done");
   slave_rst_a: assert property (s ##1 s |=> regs_reset != $past(load_req_n)) else $error("reset");
   test_role_a: assert property (test_mode_active |-> !bus_role_strap[1]) else $error("test mode");
   start_role_a: assert property (eeprom_start |-> m) else $error("start outside master role");
   cover property (test_mode_active);
   cover property (m && !all_done_n);
   cover property (s && regs_reset);
   cover property (!int_n_oe_n);
endmodule : load_ctrl_sva
bind load_ctrl load_ctrl_sva u_load_ctrl_sva (.*);
`default_nettype wire

/* test_eeprom_load_and_reset_pins.sv */
`default_nettype none
module test_eeprom_load_and_reset_pins;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'h0, rst = 1'h1, load_req_n = 1'h1, fail_mode = 1'h0;
   logic [1:0] bus_role_strap = 2'h2;
   logic [7:0] event_in = 8'h0, event_enable = 8'h0;
   logic [5:0] tp = 6'h3F;
   logic       all_done_n, eeprom_start, eeprom_busy, eeprom_ok, eeprom_fail;
   logic       regs_reset, int_n_out, int_n_oe_n, test_mode_active;
   int         fails = 0, check_count = 0, starts = 0;
   always #4 clk = ~clk;
   // Load starts since the last reset
   always @(posedge clk or posedge rst)
      if (rst)
         starts = 0;
      else if (eeprom_start === 1'h1)
         starts++;
   load_ctrl u_load_ctrl (.*, .factory_test_in_a(tp[0]), .factory_test_in_b(tp[1]), .factory_test_in_c(tp[2]),
      .factory_test_in_d(tp[3]), .factory_test_in_e(tp[4]), .factory_test_in_f(tp[5]));
   eeprom_model u_eeprom_model (.*);
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk
   task automatic restart(input logic [1:0] s);
      rst = 1'h1;
      load_req_n = 1'h1;
      bus_role_strap = s;
      step(8);
      rst = 1'h0;
      step(2);
   endtask : restart
   task automatic t_irq;
      restart(2'h3);
      for (int i = 0; i < 8; i++)
      begin
         event_in = 8'h1 << i;
         event_enable = 8'h1 << i;
         step(2);
         chk(8'h0, int_n_oe_n);
         event_enable = ~event_in;
         step(2);
         chk(8'h1, int_n_oe_n);
      end
      chk(8'h0, int_n_out);
      $display("interrupt test done");
   endtask : t_irq
   task automatic t_master(input logic f);
      fail_mode = f;
      restart(2'h2);
      tp = ~tp;
      load_req_n = 1'h0;
      step(5);
      chk(8'h1, starts[7:0]);
      chk(8'h1, all_done_n);
      chk(8'h0, test_mode_active);
      step(12);
      chk({7'h0, f}, all_done_n);
      load_req_n = 1'h1;
      step(2);
      load_req_n = 1'h0;
      step(12);
      chk({7'h0, f}, all_done_n);
      chk(8'h1, starts[7:0]);
      $display("master load test done");
   endtask : t_master
   task automatic t_slave;
      restart(2'h3);
      for (int i = 0; i < 3; i++)
      begin
         load_req_n = i[0];
         step(2);
         chk({7'h0, i[0]}, all_done_n);
         chk({7'h0, !i[0]}, regs_reset);
      end
      chk(8'h0, starts[7:0]);
      $display("slave role test done");
   endtask : t_slave
   task automatic t_test;
      restart(2'h0);
      tp = 6'h3F;
      load_req_n = 1'h0;
      step(3);
      chk(8'h1, test_mode_active);
      chk(8'h1, all_done_n);
      chk(8'h0, regs_reset);
      chk(8'h0, starts[7:0]);
      tp = 6'h3E;
      step(2);
      chk(8'h0, test_mode_active);
      $display("test role test done");
   endtask : t_test
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   initial
   begin
      #20000;
      fails++;
      stop_test;
   end
   initial
   begin
      t_irq;
      t_master(1'h0);
      t_master(1'h1);
      t_slave;
      t_test;
      stop_test;
   end
endmodule : test_eeprom_load_and_reset_pins
`default_nettype wire
